// ### design/core_pointer_power_regs.v
// core port 0, stack, data pointer, wake reload and power control registers
// Operation
// - port 0 latch holds eight read/write pin bits, all ones after reset
// - stack pointer resets to 07H so first stacked byte lands at 08H
// - push or call increments stack pointer first, then stores at new address
// - low and high data pointer bytes form one 16-bit pointer, reset zero
// - pointer select bit picks which of two data pointers is active
// - wake reload register holds the 8-bit reload value, resets zero
// - baud doubler bit 7 doubles serial port zero rate where applicable
// - bit 6 selects whether serial control bit 7 shows mode bit or framing error
// - power-on flag set by power-on reset, kept through other resets
// - bits 3 and 2 are free user flags with no hardware effect
// - deep sleep bit stops CPU and peripheral clocks, holds program counter
// - wake from deep sleep clears the bit, runs ISR, then resumes
// - light sleep bit stops only CPU clock, peripherals keep running
// - wake from light sleep clears the bit, runs ISR, then resumes
// - both sleep bits written together enter deep sleep, no light sleep after
//
// Chosen here: the AXI4-Lite slave port.
`timescale 1ns/1ps
`include "core_regs_defines.vh"

module core_pointer_power_regs
(
  input wire clk,
  input wire sys_rst,
  input wire clk_en,
  input wire cold_reset,
  // axi4-lite slave
  input wire [`ADDR_W-1:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [`ADDR_W-1:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  // cpu stack side
  input wire stack_push,
  input wire stack_pop,
  input wire [7:0] stack_push_data,
  output reg stack_store,
  output reg [7:0] stack_store_addr,
  output reg [7:0] stack_store_data,
  // serial port side
  input wire serial_mode_bit_zero,
  input wire framing_error_flag,
  output reg serial_ctrl_bit7,
  output reg baud_doubler,
  output reg frame_error_access_select,
  // sleep control
  input wire wake_event,
  output reg cpu_clk_stop,
  output reg periph_clk_stop,
  output reg wake_isr_start,
  // register outputs
  output reg [7:0] port0_pins,
  output reg [15:0] active_data_pointer,
  output reg [7:0] wake_reload_value
);

  reg [7:0] stack_top_pointer_r;
  reg [15:0] data_pointer_primary_r;
  reg [15:0] data_pointer_alternate_r;
  reg pointer_select_r;
  reg [7:0] power_control_reg_r;
  reg [`ADDR_W-1:0] aw_addr_r;
  reg aw_held_r;
  reg [7:0] w_data_r;
  reg w_lane0_r;
  reg w_held_r;
  reg sleep_deep_r;
  reg cold_sync1_r;
  reg cold_sync2_r;
  reg cold_sync3_r;
  reg cold_seen_r;

  wire [7:0] wr_idx;
  wire wr_page_ok;
  wire do_write;
  wire [7:0] rd_idx;
  wire rd_page_ok;
  wire do_read;
  wire [15:0] cur_data_pointer_primary;
  reg wr_mapped;
  reg rd_mapped;
  reg [7:0] rd_byte;
  reg [7:0] power_nxt;
  reg [7:0] stack_nxt;

  assign wr_idx = aw_addr_r[`IDX_MSB:`IDX_LSB];
  assign wr_page_ok = (aw_addr_r[`ADDR_PAGE_MSB:`ADDR_PAGE_LSB] == `ADDR_PAGE);
  // a new write waits until the previous response has been taken
  assign do_write = aw_held_r && w_held_r && !s_axi_bvalid;
  assign rd_idx = s_axi_araddr[`IDX_MSB:`IDX_LSB];
  assign rd_page_ok = (s_axi_araddr[`ADDR_PAGE_MSB:`ADDR_PAGE_LSB] == `ADDR_PAGE);
  assign do_read = s_axi_arvalid && s_axi_arready;
  // active pointer seen through the low/high byte registers
  assign cur_data_pointer_primary = pointer_select_r ? data_pointer_alternate_r :
                    data_pointer_primary_r;

  always @*
  begin
    case (wr_idx)
      `IDX_PORT0, `IDX_STACK, `IDX_DPLOW, `IDX_DPHIGH,
      `IDX_WAKE, `IDX_POWER, `IDX_AUX1:
        wr_mapped = wr_page_ok;
      default:
        wr_mapped = 1'b0;
    endcase
  end

  // unmapped indexes return zero; a mapped index off the page returns its register byte; both get an error response
  always @*
  begin
    rd_mapped = rd_page_ok;
    rd_byte = `RST_BYTE;
    case (rd_idx)
      `IDX_PORT0: rd_byte = port0_pins;
      `IDX_STACK: rd_byte = stack_top_pointer_r;
      `IDX_DPLOW: rd_byte = cur_data_pointer_primary[7:0];
      `IDX_DPHIGH: rd_byte = cur_data_pointer_primary[15:8];
      `IDX_WAKE: rd_byte = wake_reload_value;
      `IDX_POWER: rd_byte = power_control_reg_r;
      `IDX_AUX1: rd_byte = {7'h00, pointer_select_r};
      default: rd_mapped = 1'b0;
    endcase
  end

  // power control next value: software write, then hardware wake clear
  always @*
  begin
    power_nxt = power_control_reg_r;
    if (do_write && wr_mapped && w_lane0_r && wr_idx == `IDX_POWER)
    begin
      power_nxt = w_data_r;
      power_nxt[`PWR_RSVD] = power_control_reg_r[`PWR_RSVD];
      // both sleep bits together: deep sleep wins, light sleep dropped
      if (w_data_r[`PWR_PD])
        power_nxt[`PWR_IDL] = 1'b0;
    end
    // a write in the wake cycle wins; software then sees its own value
    else if (wake_event && (power_control_reg_r[`PWR_PD] ||
             power_control_reg_r[`PWR_IDL]))
    begin
      power_nxt[`PWR_PD] = 1'b0;
      power_nxt[`PWR_IDL] = 1'b0;
    end
  end

  // stack moves from the cpu take precedence over a bus write
  always @*
  begin
    stack_nxt = stack_top_pointer_r;
    if (stack_push)
      stack_nxt = stack_top_pointer_r + `STACK_STEP;
    else if (stack_pop)
      stack_nxt = stack_top_pointer_r - `STACK_STEP;
    else if (do_write && wr_mapped && w_lane0_r && wr_idx == `IDX_STACK)
      stack_nxt = w_data_r;
  end

  // axi handshake
  always @(posedge clk)
  begin
    if (sys_rst)
    begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `RESP_OKAY;
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rresp <= `RESP_OKAY;
      s_axi_rdata <= 32'h00000000;
      aw_addr_r <= {`ADDR_W{1'b0}};
      aw_held_r <= 1'b0;
      w_data_r <= `RST_BYTE;
      w_lane0_r <= 1'b0;
      w_held_r <= 1'b0;
    end
    else if (clk_en)
    begin
      // readies drop on take so a held request cannot be overrun
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_addr_r <= s_axi_awaddr;
        aw_held_r <= 1'b1;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        // only lane 0 carries a register byte
        w_data_r <= s_axi_wdata[7:0];
        w_lane0_r <= s_axi_wstrb[0];
        w_held_r <= 1'b1;
        s_axi_wready <= 1'b0;
      end
      if (do_write)
      begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_mapped ? `RESP_OKAY : `RESP_SLVERR;
        aw_held_r <= 1'b0;
        w_held_r <= 1'b0;
      end
      if (s_axi_bvalid && s_axi_bready)
      begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
      if (do_read)
      begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= {24'h000000, rd_byte};
        s_axi_rresp <= rd_mapped ? `RESP_OKAY : `RESP_SLVERR;
      end
      if (s_axi_rvalid && s_axi_rready)
      begin
        s_axi_rvalid <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

  // the power-on detector is not timed to clk: three stages, and a level
  // counts only once the last two agree; no reset, since it must run
  // while sys_rst is high
  always @(posedge clk)
  begin
    if (clk_en)
    begin
      cold_sync1_r <= cold_reset;
      cold_sync2_r <= cold_sync1_r;
      cold_sync3_r <= cold_sync2_r;
      if (cold_sync2_r == cold_sync3_r)
        cold_seen_r <= cold_sync3_r;
    end
  end

  // power-on flag survives warm resets, so it has its own reset branch
  always @(posedge clk)
  begin
    if (sys_rst)
    begin
      if (cold_seen_r)
        power_control_reg_r[`PWR_POF] <= `SET_FLAG;
      power_control_reg_r[`PWR_BAUD] <= `RST_FLAG;
      power_control_reg_r[`PWR_FESEL] <= `RST_FLAG;
      power_control_reg_r[`PWR_RSVD] <= `RSVD_INIT;
      power_control_reg_r[`PWR_GF1] <= `RST_FLAG;
      power_control_reg_r[`PWR_GF0] <= `RST_FLAG;
      power_control_reg_r[`PWR_PD] <= `RST_FLAG;
      power_control_reg_r[`PWR_IDL] <= `RST_FLAG;
    end
    else if (clk_en)
    begin
      power_control_reg_r <= power_nxt;
    end
  end

  always @(posedge clk)
  begin
    if (sys_rst)
    begin
      port0_pins <= `RST_PORT0;
      stack_top_pointer_r <= `RST_STACK;
      data_pointer_primary_r <= `RST_DATA_POINTER_PRIMARY;
      data_pointer_alternate_r <= `RST_DATA_POINTER_PRIMARY;
      pointer_select_r <= `RST_AUX1;
      wake_reload_value <= `RST_WAKE;
    end
    else if (clk_en)
    begin
      stack_top_pointer_r <= stack_nxt;
      if (do_write && wr_mapped && w_lane0_r)
      begin
        case (wr_idx)
          `IDX_PORT0: port0_pins <= w_data_r;
          `IDX_DPLOW:
          begin
            if (pointer_select_r)
              data_pointer_alternate_r[7:0] <= w_data_r;
            else
              data_pointer_primary_r[7:0] <= w_data_r;
          end
          `IDX_DPHIGH:
          begin
            if (pointer_select_r)
              data_pointer_alternate_r[15:8] <= w_data_r;
            else
              data_pointer_primary_r[15:8] <= w_data_r;
          end
          // FFH at prescale 1/1 is stored as written; software must avoid it
          `IDX_WAKE: wake_reload_value <= w_data_r;
          // only the select bit is stored; the rest reads zero
          `IDX_AUX1: pointer_select_r <= w_data_r[`AUX1_DPS];
          default: ;
        endcase
      end
    end
  end

  // stack store strobe and the registered copy of the active pointer
  always @(posedge clk)
  begin
    if (sys_rst)
    begin
      stack_store <= 1'b0;
      stack_store_addr <= `RST_BYTE;
      stack_store_data <= `RST_BYTE;
      active_data_pointer <= `RST_DATA_POINTER_PRIMARY;
    end
    else if (clk_en)
    begin
      // store goes to the already incremented address
      stack_store <= stack_push;
      stack_store_addr <= stack_top_pointer_r + `STACK_STEP;
      stack_store_data <= stack_push_data;
      active_data_pointer <= cur_data_pointer_primary;
    end
  end

  // serial side copies; taken from the next value so they follow a write at once
  always @(posedge clk)
  begin
    if (sys_rst)
    begin
      serial_ctrl_bit7 <= 1'b0;
      baud_doubler <= 1'b0;
      frame_error_access_select <= 1'b0;
    end
    else if (clk_en)
    begin
      baud_doubler <= power_nxt[`PWR_BAUD];
      frame_error_access_select <= power_nxt[`PWR_FESEL];
      serial_ctrl_bit7 <= power_nxt[`PWR_FESEL] ? framing_error_flag :
                          serial_mode_bit_zero;
    end
  end

  // sleep outputs; the block keeps running, clock gating happens outside
  always @(posedge clk)
  begin
    if (sys_rst)
    begin
      cpu_clk_stop <= 1'b0;
      periph_clk_stop <= 1'b0;
      wake_isr_start <= 1'b0;
      sleep_deep_r <= 1'b0;
    end
    else if (clk_en)
    begin
      // deep sleep stops everything, light sleep only the cpu
      cpu_clk_stop <= power_nxt[`PWR_PD] | power_nxt[`PWR_IDL];
      periph_clk_stop <= power_nxt[`PWR_PD];
      sleep_deep_r <= power_nxt[`PWR_PD];
      // cpu takes the waking source isr; return lands after the sleep entry
      wake_isr_start <= wake_event && (cpu_clk_stop || sleep_deep_r) &&
                        !(power_nxt[`PWR_PD] | power_nxt[`PWR_IDL]);
    end
  end

endmodule // core_pointer_power_regs

// ### design/core_regs_defines.vh
// constants for the core pointer and power register bank
`ifndef CORE_REGS_DEFINES_VH
`define CORE_REGS_DEFINES_VH
// register indexes; byte address is index times four
`define IDX_PORT0 8'h80
`define IDX_STACK 8'h81
`define IDX_DPLOW 8'h82
`define IDX_DPHIGH 8'h83
`define IDX_WAKE 8'h86
`define IDX_POWER 8'h87
`define IDX_AUX1 8'hA2
`define ADDR_W 12
`define IDX_LSB 2
`define IDX_MSB 9
`define ADDR_PAGE_LSB 10
`define ADDR_PAGE_MSB 11
`define ADDR_PAGE 2'h0
// reset values
`define RST_PORT0 8'hFF
`define RST_STACK 8'h07
`define RST_DATA_POINTER_PRIMARY 16'h0000
`define RST_WAKE 8'h00
`define RST_FLAG 1'b0
`define SET_FLAG 1'b1
`define RST_BYTE 8'h00
`define RST_AUX1 1'b0
// power control fields
`define PWR_BAUD 7
`define PWR_FESEL 6
`define PWR_RSVD 5
`define PWR_POF 4
`define PWR_GF1 3
`define PWR_GF0 2
`define PWR_PD 1
`define PWR_IDL 0
`define RSVD_INIT 1'b0
`define AUX1_DPS 0
// axi responses
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`define STACK_STEP 8'h01
`endif

// ### tb/core_regs_properties.sv
// assertions for the core pointer and power register bank
`timescale 1ns/1ps
module core_regs_properties
(
  input wire clk,
  input wire sys_rst,
  input wire clk_en,
  input wire stack_push,
  input wire stack_store,
  input wire [7:0] stack_store_addr,
  input wire s_axi_awvalid,
  input wire s_axi_awready,
  input wire s_axi_wvalid,
  input wire s_axi_wready,
  input wire s_axi_bvalid,
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire s_axi_rvalid,
  input wire serial_mode_bit_zero,
  input wire framing_error_flag,
  input wire serial_ctrl_bit7,
  input wire frame_error_access_select,
  input wire cpu_clk_stop,
  input wire periph_clk_stop,
  input wire wake_event
);
  default clocking cb @(posedge clk);
  endclocking
  // a low clock enable freezes every flop, so those cycles prove nothing
  default disable iff (sys_rst || !clk_en);
  chk_push_store: assert property (stack_push |=> stack_store)
    else $error("push not stored");
  chk_store_only_push: assert property (!stack_push |=> !stack_store)
    else $error("stray store");
  chk_store_step: assert property (stack_push && $past(stack_push) |=>
    stack_store_addr == $past(stack_store_addr) + 8'h01) else $error("store address step");
  chk_write_answer: assert property (s_axi_awvalid && s_axi_awready &&
    s_axi_wvalid && s_axi_wready |=> !s_axi_bvalid ##1 s_axi_bvalid) else $error("write timing");
  chk_read_answer: assert property (s_axi_arvalid && s_axi_arready |=>
    s_axi_rvalid && !s_axi_arready) else $error("read timing");
  chk_frame_select: assert property (!$past(sys_rst) |-> serial_ctrl_bit7 ==
    (frame_error_access_select ? $past(framing_error_flag) : $past(serial_mode_bit_zero)))
    else $error("serial bit 7 source");
  chk_deep_stops_cpu: assert property (periph_clk_stop |-> cpu_clk_stop)
    else $error("peripherals stopped alone");
  chk_wake_clears: assert property (wake_event && cpu_clk_stop |-> ##[1:2] !cpu_clk_stop)
    else $error("wake left clock stopped");
  cover property (stack_push ##1 stack_push);
  cover property (wake_event && periph_clk_stop);
  cover property (frame_error_access_select && framing_error_flag);
endmodule // core_regs_properties

bind core_pointer_power_regs core_regs_properties chk_u (.clk, .sys_rst, .clk_en, .stack_push,
  .stack_store, .stack_store_addr, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
  .s_axi_bvalid, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .serial_mode_bit_zero,
  .framing_error_flag, .serial_ctrl_bit7, .frame_error_access_select, .cpu_clk_stop,
  .periph_clk_stop, .wake_event);

// ### tb/core_pointer_power_regs_tb_top.sv
// self-checking bench for the core pointer and power register bank
`timescale 1ns/1ps
module core_pointer_power_regs_tb_top;
  reg clk = 1'h0, sys_rst = 1'h1, cold_reset = 1'h1, s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0;
  reg s_axi_bready = 1'h0, s_axi_arvalid = 1'h0, s_axi_rready = 1'h0, stack_push = 1'h0;
  reg stack_pop = 1'h0, serial_mode_bit_zero = 1'h1, framing_error_flag = 1'h0, wake_event = 1'h0;
  reg clk_en = 1'h1;
  reg [3:0] s_axi_wstrb = 4'hF;
  reg [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
  reg [31:0] s_axi_wdata = 32'h0, v;
  reg [7:0] stack_push_data = 8'h00;
  reg [1:0] r;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, stack_store;
  wire serial_ctrl_bit7, baud_doubler, frame_error_access_select, cpu_clk_stop;
  wire periph_clk_stop, wake_isr_start;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  wire [7:0] stack_store_addr, stack_store_data, port0_pins, wake_reload_value;
  wire [15:0] active_data_pointer;
  integer n_mismatch = 0, check_count = 0, i;
  always #2.5 clk = ~clk;
  core_pointer_power_regs dut_u (.clk, .sys_rst, .clk_en, .cold_reset, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .stack_push,
    .stack_pop, .stack_push_data, .stack_store, .stack_store_addr, .stack_store_data,
    .serial_mode_bit_zero, .framing_error_flag, .serial_ctrl_bit7, .baud_doubler,
    .frame_error_access_select, .wake_event, .cpu_clk_stop, .periph_clk_stop, .wake_isr_start,
    .port0_pins, .active_data_pointer, .wake_reload_value);
  task cmp(input [31:0] g, input [31:0] e);
    begin
      check_count = check_count + 1;
      if (g !== e)
      begin
        n_mismatch = n_mismatch + 1;
        $display("Error %0t: got %h want %h", $time, g, e);
      end
    end
  endtask
  task results;
    begin
      $display("checks %0d mismatches %0d", check_count, n_mismatch);
      if (n_mismatch == 0 && check_count > 0)
        $display("verification passed");
      else
        $display("verification failed");
      $finish;
    end
  endtask
  task hang;
    begin
      n_mismatch = n_mismatch + 1;
      $display("Error %0t: timeout", $time);
      results;
    end
  endtask
  // active_data_pointer trails its register by one clock, so allow two
  task tick;
    repeat (2) @(posedge clk);
  endtask
  task wr(input [11:0] a, input [31:0] d);
    integer n;
    begin
      @(posedge clk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'h1;
      s_axi_wvalid <= 1'h1;
      s_axi_bready <= 1'h1;
      for (n = 0; s_axi_bvalid !== 1'h1; n = n + 1)
      begin
        if (n == 40) hang;
        @(posedge clk);
        if (s_axi_awready === 1'h1) s_axi_awvalid <= 1'h0;
        if (s_axi_wready === 1'h1) s_axi_wvalid <= 1'h0;
      end
      s_axi_bready <= 1'h0;
      r = s_axi_bresp;
    end
  endtask
  task rd(input [11:0] a);
    integer n;
    begin
      @(posedge clk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'h1;
      s_axi_rready <= 1'h1;
      for (n = 0; s_axi_rvalid !== 1'h1; n = n + 1)
      begin
        if (n == 40) hang;
        @(posedge clk);
        if (s_axi_arready === 1'h1) s_axi_arvalid <= 1'h0;
      end
      s_axi_rready <= 1'h0;
      v = s_axi_rdata;
      r = s_axi_rresp;
    end
  endtask
  task rc(input [11:0] a, input [31:0] e);
    begin
      rd(a);
      cmp(v, e);
    end
  endtask
  task wk;
    integer n;
    begin
      @(posedge clk);
      wake_event <= 1'h1;
      @(posedge clk);
      wake_event <= 1'h0;
      for (n = 0; wake_isr_start !== 1'h1; n = n + 1)
      begin
        if (n == 10) hang;
        @(posedge clk);
      end
    end
  endtask
  task rst(input c);
    begin
      sys_rst <= 1'h1;
      cold_reset <= c;
      repeat (12) @(posedge clk);
      sys_rst <= 1'h0;
      cold_reset <= 1'h0;
    end
  endtask
  initial
  begin
    rst(1'h1);
    rc(12'h200, 32'hFF);
    rc(12'h204, 32'h07);
    rc(12'h208, 32'h00);
    rc(12'h20C, 32'h00);
    rc(12'h218, 32'h00);
    rc(12'h21C, 32'h10);
    $display("reset test done");
    @(posedge clk);
    stack_push <= 1'h1;
    stack_push_data <= 8'h5A;
    @(posedge clk);
    stack_push_data <= 8'hC3;
    @(posedge clk);
    stack_push <= 1'h0;
    cmp({stack_store, stack_store_addr, stack_store_data}, {1'h1, 8'h08, 8'h5A});
    @(posedge clk);
    cmp({stack_store, stack_store_addr, stack_store_data}, {1'h1, 8'h09, 8'hC3});
    stack_pop <= 1'h1;
    @(posedge clk);
    stack_pop <= 1'h0;
    rc(12'h204, 32'h08);
    clk_en <= 1'h0;
    stack_push <= 1'h1;
    @(posedge clk);
    stack_push <= 1'h0;
    @(posedge clk);
    clk_en <= 1'h1;
    rc(12'h204, 32'h08);
    $display("stack test done");
    wr(12'h200, 32'h5A);
    rc(12'h200, 32'h5A);
    cmp(r, 2'h0);
    s_axi_wstrb <= 4'h0;
    wr(12'h200, 32'h33);
    s_axi_wstrb <= 4'hF;
    cmp(r, 2'h0);
    rc(12'h200, 32'h5A);
    wr(12'h218, 32'hFE);
    rc(12'h218, 32'hFE);
    cmp({port0_pins, wake_reload_value}, 16'h5AFE);
    wr(12'h21C, 32'h2C);
    rc(12'h21C, 32'h0C);
    wr(12'h0FC, 32'h1);
    cmp(r, 2'h2);
    rc(12'h0FC, 32'h0);
    cmp(r, 2'h2);
    wr(12'h208, 32'h34);
    wr(12'h20C, 32'h12);
    tick;
    cmp(active_data_pointer, 16'h1234);
    wr(12'h288, 32'h1);
    wr(12'h208, 32'h78);
    tick;
    cmp(active_data_pointer, 16'h0078);
    wr(12'h288, 32'h0);
    rc(12'h208, 32'h34);
    $display("register test done");
    wr(12'h21C, 32'h80);
    tick;
    cmp({baud_doubler, frame_error_access_select, serial_ctrl_bit7}, 3'h5);
    wr(12'h21C, 32'h40);
    tick;
    cmp({baud_doubler, frame_error_access_select, serial_ctrl_bit7}, 3'h2);
    framing_error_flag <= 1'h1;
    serial_mode_bit_zero <= 1'h0;
    tick;
    cmp(serial_ctrl_bit7, 1'h1);
    for (i = 1; i < 4; i = i + 1)
    begin
      wr(12'h21C, i);
      tick;
      cmp({cpu_clk_stop, periph_clk_stop}, {1'h1, i[1]});
      rc(12'h21C, (i == 3) ? 32'h2 : i);
      wk;
      tick;
      cmp({cpu_clk_stop, periph_clk_stop}, 2'h0);
      rc(12'h21C, 32'h0);
    end
    $display("power test done");
    wr(12'h21C, 32'h10);
    @(posedge clk);
    rst(1'h0);
    rc(12'h21C, 32'h10);
    rc(12'h200, 32'hFF);
    wr(12'h21C, 32'h00);
    @(posedge clk);
    rst(1'h0);
    rc(12'h21C, 32'h00);
    $display("warm reset test done");
    rst(1'h1);
    rc(12'h21C, 32'h10);
    $display("cold reset test done");
    results;
  end
endmodule // core_pointer_power_regs_tb_top
